// ---- lsl_pkg.sv ----
// Constants and types shared by the serial link block
package lsl_pkg;

  // ***************************************************************
  // Geometry of the link
  // ***************************************************************
  localparam int WORD_W     = 28;
  localparam int LANES      = 4;
  localparam int WORD_SLOTS = 7;
  localparam int SLOT_W     = 3;
  localparam logic [SLOT_W-1:0] LAST_SLOT = 3'h6;
  // Forwarded clock is high for the first slots of a word
  localparam logic [SLOT_W-1:0] FWD_HIGH_SLOTS = 3'h4;
  // Receive strobe stays high this many cycles after a new word
  localparam logic [SLOT_W-1:0] STROBE_HIGH = 3'h3;

  // ***************************************************************
  // Timing
  // ***************************************************************
  localparam int CLK_FREQ_HZ  = 100_000_000;
  localparam int LOCK_TIME_MS = 10;
  localparam int LOCK_CYCLES  = (LOCK_TIME_MS * (CLK_FREQ_HZ / 1000));
  localparam int LOCK_CNT_W   = 20;

  // ***************************************************************
  // Transmit power states
  // ***************************************************************
  typedef enum logic [2:0] {
    TX_SLEEP = 3'b001,
    TX_LOCK  = 3'b010,
    TX_RUN   = 3'b100
  } lsl_tx_state_t;

  typedef struct packed {
    // Transmit input synchronisers
    logic                  txClkS1;
    logic                  txClkS2;
    logic                  txClkPrev;
    logic [WORD_W-1:0]     txInS1;
    logic [WORD_W-1:0]     txInS2;
    logic                  txSleepS1;
    logic                  txSleepS2;
    // Transmit core
    lsl_tx_state_t         txState;
    logic [LOCK_CNT_W-1:0] lockCnt;
    logic [WORD_W-1:0]     txWord;
    logic [SLOT_W-1:0]     txSlot;
    logic                  txActive;
    logic [LANES-1:0]      txLaneP;
    logic [LANES-1:0]      txLaneN;
    logic                  txOe;
    logic                  fwdP;
    logic                  fwdN;
    // Receive input synchronisers
    logic [LANES-1:0]      rxLaneS1;
    logic [LANES-1:0]      rxLaneS2;
    logic                  rxFwdS1;
    logic                  rxFwdS2;
    logic                  rxFwdPrev;
    logic                  rxSleepS1;
    logic                  rxSleepS2;
    // Receive core
    logic [WORD_W-1:0]     rxShift;
    logic [SLOT_W-1:0]     rxCnt;
    logic                  rxBusy;
    logic [WORD_W-1:0]     rx_parallel_out;
    logic                  rxStrobe;
    logic [SLOT_W-1:0]     strobeCnt;
  } lsl_state_t;

endpackage

// ---- lsl_serdes_link.sv ----
// Transmit serializer and receive deserializer of the 28-bit serial link
`timescale 1ns/1ps
`default_nettype none

module lsl_serdes_link
  import lsl_pkg::*;
#(
  parameter int LOCK_WAIT = lsl_pkg::LOCK_CYCLES
) (
  // Clock and reset
  input  wire logic                       sys_clk,
  input  wire logic                       srst,
  // Transmit parallel side
  input  wire logic [lsl_pkg::WORD_W-1:0] txParallelIn,
  input  wire logic                       txWordClock,
  input  wire logic                       txSleep_n,
  // Transmit serial side
  output var  logic [lsl_pkg::LANES-1:0]  txSerialLaneP,
  output var  logic [lsl_pkg::LANES-1:0]  txSerialLaneN,
  output var  logic                       txSerialLaneOe,
  output var  logic                       fwdClockP,
  output var  logic                       fwdClockN,
  output var  logic                       fwdClockOe,
  // Receive serial side
  input  wire logic [lsl_pkg::LANES-1:0]  rxSerialLaneP,
  input  wire logic                       rxFwdClockP,
  input  wire logic                       rxSleep_n,
  // Receive parallel side
  output var  logic [lsl_pkg::WORD_W-1:0] rxParallelOut,
  output var  logic                       rxWordStrobe
);
  import lsl_pkg::*;

  lsl_state_t st_ff;
  lsl_state_t nxt_st;
  logic       txEdge;
  logic       rxEdge;

  assign txEdge = st_ff.txClkS2 & ~st_ff.txClkPrev;
  assign rxEdge = st_ff.rxFwdS2 & ~st_ff.rxFwdPrev;

  // ***************************************************************
  // Next state
  // ***************************************************************
  always_comb begin
    nxt_st = st_ff;
    // Two-stage synchronisers on every pin input except srst
    nxt_st.txClkS1   = txWordClock;
    nxt_st.txClkS2   = st_ff.txClkS1;
    nxt_st.txClkPrev = st_ff.txClkS2;
    nxt_st.txInS1    = txParallelIn;
    nxt_st.txInS2    = st_ff.txInS1;
    nxt_st.txSleepS1 = txSleep_n;
    nxt_st.txSleepS2 = st_ff.txSleepS1;
    nxt_st.rxLaneS1  = rxSerialLaneP;
    nxt_st.rxLaneS2  = st_ff.rxLaneS1;
    nxt_st.rxFwdS1   = rxFwdClockP;
    nxt_st.rxFwdS2   = st_ff.rxFwdS1;
    nxt_st.rxFwdPrev = st_ff.rxFwdS2;
    nxt_st.rxSleepS1 = rxSleep_n;
    nxt_st.rxSleepS2 = st_ff.rxSleepS1;

    // Transmit power and lock sequencing
    unique case (st_ff.txState)
      TX_SLEEP: begin
        nxt_st.lockCnt = '0;
        if (st_ff.txSleepS2) begin
          nxt_st.txState = TX_LOCK;
        end
      end
      TX_LOCK: begin
        if (st_ff.lockCnt == LOCK_CNT_W'(LOCK_WAIT - 1)) begin
          nxt_st.txState = TX_RUN;
        end else begin
          nxt_st.lockCnt = st_ff.lockCnt + 1'b1;
        end
      end
      TX_RUN: begin
      end
      default: begin
        nxt_st.txState = TX_SLEEP;
      end
    endcase
    if (!st_ff.txSleepS2) begin
      nxt_st.txState = TX_SLEEP;
      nxt_st.lockCnt = '0;
    end

    // Word capture and slot walk, one bit per cycle per lane
    if (txEdge && st_ff.txState == TX_RUN) begin
      nxt_st.txWord   = st_ff.txInS2;
      nxt_st.txSlot   = '0;
      nxt_st.txActive = 1'b1;
    end else if (st_ff.txActive) begin
      if (st_ff.txSlot == LAST_SLOT) begin
        nxt_st.txActive = 1'b0;
      end else begin
        nxt_st.txSlot = st_ff.txSlot + 1'b1;
      end
    end
    if (nxt_st.txState != TX_RUN) begin
      nxt_st.txActive = 1'b0;
    end

    // Serial outputs; quiet but driven during lock, released in sleep
    for (int l = 0; l < LANES; l++) begin
      nxt_st.txLaneP[l] = nxt_st.txActive
                          & nxt_st.txWord[l*WORD_SLOTS + int'(nxt_st.txSlot)];
    end
    nxt_st.txLaneN = ~nxt_st.txLaneP;
    nxt_st.fwdP    = nxt_st.txActive && (nxt_st.txSlot < FWD_HIGH_SLOTS);
    nxt_st.fwdN    = ~nxt_st.fwdP;
    nxt_st.txOe    = (nxt_st.txState != TX_SLEEP);

    // Receive: slot 0 arrives with the rise of the forwarded clock
    if (!st_ff.rxSleepS2) begin
      nxt_st.rxBusy   = 1'b0;
      nxt_st.rxStrobe = 1'b0;
    end else begin
      if (rxEdge) begin
        for (int l = 0; l < LANES; l++) begin
          nxt_st.rxShift[l*WORD_SLOTS] = st_ff.rxLaneS2[l];
        end
        nxt_st.rxCnt  = 3'h1;
        nxt_st.rxBusy = 1'b1;
      end else if (st_ff.rxBusy) begin
        for (int l = 0; l < LANES; l++) begin
          nxt_st.rxShift[l*WORD_SLOTS + int'(st_ff.rxCnt)] = st_ff.rxLaneS2[l];
        end
        if (st_ff.rxCnt == LAST_SLOT) begin
          nxt_st.rxBusy    = 1'b0;
          nxt_st.rx_parallel_out     = nxt_st.rxShift;
          nxt_st.rxStrobe  = 1'b1;
          nxt_st.strobeCnt = '0;
        end else begin
          nxt_st.rxCnt = st_ff.rxCnt + 1'b1;
        end
      end
      if (st_ff.rxStrobe && !(st_ff.rxBusy && st_ff.rxCnt == LAST_SLOT)) begin
        if (st_ff.strobeCnt == STROBE_HIGH - 3'h1) begin
          nxt_st.rxStrobe = 1'b0;
        end else begin
          nxt_st.strobeCnt = st_ff.strobeCnt + 1'b1;
        end
      end
    end
  end

  // ***************************************************************
  // State register
  // ***************************************************************
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      st_ff         <= '0;
      st_ff.txState <= TX_SLEEP;
      st_ff.txLaneN <= '1;
      st_ff.fwdN    <= 1'b1;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign txSerialLaneP  = st_ff.txLaneP;
  assign txSerialLaneN  = st_ff.txLaneN;
  assign txSerialLaneOe = st_ff.txOe;
  assign fwdClockP      = st_ff.fwdP;
  assign fwdClockN      = st_ff.fwdN;
  assign fwdClockOe     = st_ff.txOe;
  assign rxParallelOut  = st_ff.rx_parallel_out;
  assign rxWordStrobe   = st_ff.rxStrobe;

  // ***************************************************************
  // Checks
  // ***************************************************************
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);

  sleep_release_a: assert property (!st_ff.txSleepS2 |=> !txSerialLaneOe && !fwdClockOe)
    else $error("transmit outputs driven while asleep");
  word_capture_a: assert property (txEdge && st_ff.txState == TX_RUN
      |=> st_ff.txWord == $past(st_ff.txInS2) && st_ff.txSlot == 3'h0)
    else $error("word not captured on clock edge");
  // Slot 0 shows one cycle after the edge, so slot 6 stands seven cycles after it
  slot_walk_a: assert property (txEdge && st_ff.txState == TX_RUN
      && st_ff.txSleepS2 ##1 (!txEdge && st_ff.txSleepS2)[*6]
      |=> st_ff.txSlot == LAST_SLOT && st_ff.txActive)
    else $error("seven slot walk broken");
  lane_map_a: assert property (st_ff.txActive |-> txSerialLaneP[3]
      == st_ff.txWord[3*WORD_SLOTS + int'(st_ff.txSlot)] && txSerialLaneN == ~txSerialLaneP)
    else $error("lane bit does not match word");
  fwd_shape_a: assert property ($rose(fwdClockP) |-> st_ff.txSlot == 3'h0
      ##4 !fwdClockP)
    else $error("forwarded clock shape wrong");
  lock_quiet_a: assert property (st_ff.txState == TX_LOCK |-> !fwdClockP
      && txSerialLaneP == '0 && txSerialLaneOe)
    else $error("outputs toggle before lock");
  lock_done_a: assert property (st_ff.txState == TX_LOCK && st_ff.txSleepS2
      && st_ff.lockCnt == LOCK_CNT_W'(LOCK_WAIT - 1) |=> st_ff.txState == TX_RUN)
    else $error("lock wait length wrong");
  rx_update_a: assert property ($changed(rxParallelOut) |-> $rose(rxWordStrobe))
    else $error("parallel output changed without strobe");
  rx_hold_a: assert property (!st_ff.rxSleepS2 |=> $stable(rxParallelOut) && !rxWordStrobe)
    else $error("receive output moved while asleep");

  word_sent_c: cover property (txEdge && st_ff.txState == TX_RUN ##7 !st_ff.txActive);
  word_recv_c: cover property ($rose(rxWordStrobe));
  lock_reached_c: cover property (st_ff.txState == TX_LOCK ##1 st_ff.txState == TX_RUN);
  rx_sleep_c: cover property (!st_ff.rxSleepS2 && rxEdge);

endmodule
`default_nettype wire

// ---- lsl_far_end.sv ----
// Far side model: word source ahead of the transmitter and cable to the receiver
`timescale 1ns/1ps
`default_nettype none
module lsl_far_end
  import lsl_pkg::*;
(
  // Clock and source control
  input  wire logic                       sys_clk,
  input  wire logic                       wordEn,
  input  wire logic [lsl_pkg::WORD_W-1:0] wordIn,
  output var  logic                       wordTaken,
  // Source pins
  output var  logic [lsl_pkg::WORD_W-1:0] txParallelIn,
  output var  logic                       txWordClock,
  // Cable
  input  wire logic [lsl_pkg::LANES-1:0]  txSerialLaneP,
  input  wire logic                       txSerialLaneOe,
  input  wire logic                       fwdClockP,
  input  wire logic                       fwdClockOe,
  output var  logic [lsl_pkg::LANES-1:0]  rxSerialLaneP,
  output var  logic                       rxFwdClockP
);
  logic [2:0] phase    = 3'h0;
  logic [3:0] laneLast = 4'h0;
  logic       fwdLast  = 1'b0;
  initial begin
    wordTaken = 1'b0;
    txWordClock = 1'b0;
    txParallelIn = 28'h0;
  end
  // Seven-cycle word period; data is set two cycles before the rise
  always @(posedge sys_clk) begin
    wordTaken <= 1'b0;
    if (phase != 3'h0 || wordEn) begin
      phase <= (phase == 3'h6) ? 3'h0 : phase + 3'h1;
      txWordClock <= (phase >= 3'h2 && phase <= 3'h5);
    end
    if (phase == 3'h0 && wordEn) begin
      txParallelIn <= wordIn;
      wordTaken <= 1'b1;
    end
    if (txSerialLaneOe) laneLast <= txSerialLaneP;
    if (fwdClockOe) fwdLast <= fwdClockP;
  end
  // A released line shows the inverse of its last driven level
  assign rxSerialLaneP = txSerialLaneOe ? txSerialLaneP : ~laneLast;
  assign rxFwdClockP   = fwdClockOe ? fwdClockP : ~fwdLast;
endmodule
`default_nettype wire

// ---- tb_lsl_serdes_link.sv ----
// Self-checking bench of the serial link, looped back through the far side model
`timescale 1ns/1ps
`default_nettype none
module tb_lsl_serdes_link;
  import lsl_pkg::*;
  localparam int LW = 30;
  typedef struct packed {logic [WORD_W-1:0] word; logic [WORD_W-1:0] expOut;} lsl_row_t;
  lsl_row_t rows [6] = '{'{28'hfffffff, 28'hfffffff}, '{28'h0000001, 28'h0000001},
    '{28'h8000000, 28'h8000000}, '{28'h5555555, 28'h5555555},
    '{28'haaaaaaa, 28'haaaaaaa}, '{28'h1234567, 28'h1234567}};
  logic sys_clk = 1'b0, srst = 1'b1, txSleep_n = 1'b1, rxSleep_n = 1'b1, wordEn = 1'b0;
  logic rxChk = 1'b0, fwdPrev = 1'b0, strobePrev = 1'b0, fwdClockN;
  logic wordTaken, txWordClock, txSerialLaneOe, fwdClockP, fwdClockOe, rxFwdClockP, rxWordStrobe;
  logic [WORD_W-1:0] wordIn = 28'h0, txParallelIn, rxParallelOut, acc, lastOut;
  logic [LANES-1:0]  txSerialLaneP, txSerialLaneN, rxSerialLaneP;
  logic [WORD_W-1:0] txQ [$], rxQ [$];
  int sl = 7, error_cnt = 0, n_checks = 0;

  lsl_serdes_link #(.LOCK_WAIT(LW)) u_lsl_serdes_link (.sys_clk(sys_clk), .srst(srst),
    .txParallelIn(txParallelIn), .txWordClock(txWordClock), .txSleep_n(txSleep_n),
    .txSerialLaneP(txSerialLaneP), .txSerialLaneN(txSerialLaneN),
    .txSerialLaneOe(txSerialLaneOe),
    .fwdClockP(fwdClockP), .fwdClockN(fwdClockN), .fwdClockOe(fwdClockOe),
    .rxSerialLaneP(rxSerialLaneP), .rxFwdClockP(rxFwdClockP), .rxSleep_n(rxSleep_n),
    .rxParallelOut(rxParallelOut), .rxWordStrobe(rxWordStrobe));
  lsl_far_end u_lsl_far_end (.sys_clk(sys_clk), .wordEn(wordEn), .wordIn(wordIn),
    .wordTaken(wordTaken), .txParallelIn(txParallelIn), .txWordClock(txWordClock),
    .txSerialLaneP(txSerialLaneP), .txSerialLaneOe(txSerialLaneOe), .fwdClockP(fwdClockP),
    .fwdClockOe(fwdClockOe), .rxSerialLaneP(rxSerialLaneP), .rxFwdClockP(rxFwdClockP));

  // ***************************************************************
  // Compare and report
  // ***************************************************************
  task automatic chk28(input logic [WORD_W-1:0] got, input logic [WORD_W-1:0] exp,
                       input string what);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic chk1(input logic got, input logic exp, input string what);
    chk28({27'h0, got}, {27'h0, exp}, what);
  endtask
  task automatic final_report();
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // Hands one word to the source; caller lowers wordEn after the last one
  task automatic send(input logic [WORD_W-1:0] w, input logic [WORD_W-1:0] e,
                      input bit doTx, input bit doRx);
    int n;
    n = 0;
    wordIn <= w;
    wordEn <= 1'b1;
    if (doTx) txQ.push_back(w);
    if (doRx) rxQ.push_back(e);
    do begin
      @(posedge sys_clk);
      n++;
    end while (wordTaken !== 1'b1 && n < 20);
  endtask

  // ***************************************************************
  // Monitors of the serial lanes and the rebuilt word
  // ***************************************************************
  always @(posedge sys_clk) begin
    if (fwdClockOe === 1'b1 && fwdClockP === 1'b1 && fwdPrev === 1'b0) sl = 0;
    fwdPrev = fwdClockP;
    if (sl < 7) begin
      chk1(fwdClockP, sl < 4, "fwd clock shape");
      chk1(fwdClockN, sl >= 4, "fwd clock n");
      chk28({24'h0, txSerialLaneN}, {24'h0, ~txSerialLaneP}, "lane n");
      for (int l = 0; l < LANES; l++) acc[7*l+sl] = txSerialLaneP[l];
      sl++;
      if (sl == 7) chk28(acc, txQ.size() ? txQ.pop_front() : ~acc, "lanes");
    end
  end
  always @(posedge sys_clk) begin
    if (rxChk && rxWordStrobe === 1'b1 && strobePrev === 1'b0)
      chk28(rxParallelOut, rxQ.size() ? rxQ.pop_front() : ~rxParallelOut, "rx");
    strobePrev = rxWordStrobe;
  end

  // ***************************************************************
  // Stimulus
  // ***************************************************************
  always #5 sys_clk = ~sys_clk;
  initial begin
    #20000;
    error_cnt++;
    $display("[FAIL] %0t watchdog", $time);
    final_report();
  end
  initial begin
    repeat (3) @(posedge sys_clk);
    srst <= 1'b0;
    chk1(txSerialLaneOe, 1'b0, "oe in reset");
    chk1(rxWordStrobe, 1'b0, "strobe in reset");
    chk28(rxParallelOut, 28'h0, "rx in reset");
    for (int n = 0; n < 20 && txSerialLaneOe !== 1'b1; n++) @(posedge sys_clk);
    send(28'h7654321, 28'h0, 0, 0);
    wordEn <= 1'b0;
    repeat (LW) begin
      @(posedge sys_clk);
      chk28({24'h0, txSerialLaneP}, 28'h0, "lanes in lock");
    end
    // A released cable reads as a rising clock, so receive checks start once locked
    rxChk <= 1'b1;
    foreach (rows[i]) send(rows[i].word, rows[i].expOut, 1, 1);
    wordEn <= 1'b0;
    repeat (20) @(posedge sys_clk);
    lastOut = rxParallelOut;
    rxSleep_n <= 1'b0;
    rxChk <= 1'b0;
    repeat (4) @(posedge sys_clk);
    send(28'h0f0f0f0, 28'h0, 1, 0);
    wordEn <= 1'b0;
    repeat (16) begin
      @(posedge sys_clk);
      chk28(rxParallelOut, lastOut, "held out");
      chk1(rxWordStrobe, 1'b0, "strobe in sleep");
    end
    rxSleep_n <= 1'b1;
    rxChk <= 1'b1;
    repeat (4) @(posedge sys_clk);
    send(28'h0f0f0f0, 28'h0f0f0f0, 1, 1);
    wordEn <= 1'b0;
    repeat (20) @(posedge sys_clk);
    rxChk <= 1'b0;
    txSleep_n <= 1'b0;
    repeat (4) @(posedge sys_clk);
    chk1(txSerialLaneOe, 1'b0, "lanes released");
    chk1(fwdClockOe, 1'b0, "fwd released");
    txSleep_n <= 1'b1;
    repeat (LW + 8) @(posedge sys_clk);
    chk1(fwdClockOe, 1'b1, "fwd driven again");
    send(28'h2468ace, 28'h0, 1, 0);
    wordEn <= 1'b0;
    repeat (20) @(posedge sys_clk);
    chk28(28'(txQ.size() + rxQ.size()), 28'h0, "words pending");
    final_report();
  end
endmodule
`default_nettype wire
